/* src/ppm_pkg.sv */
// shared constants and types of the per-port management block
package ppm_pkg;
   localparam int          NPORT       = 6;
   localparam int          CLK_NS      = 10;
   localparam int          HW_BUSY_NS  = 1000000;
   localparam int          HW_BUSY_CYC = HW_BUSY_NS / CLK_NS;
   localparam int          SW_RST_NS   = 2000;
   localparam int          SW_RST_CYC  = SW_RST_NS / CLK_NS;
   localparam int          MII100_NS   = 40;
   localparam int          MII10_NS    = 400;
   localparam int          HALF100     = MII100_NS / (2 * CLK_NS);
   localparam int          HALF10      = MII10_NS / (2 * CLK_NS);
   localparam logic [16:0] STRAP_CYC   = 17'h00003;
   localparam logic [5:0]  PRE_LEN     = 6'h20;
   localparam logic [5:0]  HDR_LAST    = 6'h0d;
   localparam logic [5:0]  DAT_LAST    = 6'h0f;
   localparam logic [1:0]  SOF         = 2'h1;
   localparam logic [1:0]  OP_WR       = 2'h1;
   localparam logic [1:0]  OP_RD       = 2'h2;
   // register indices
   localparam logic [4:0]  R_CTRL      = 5'h00;
   localparam logic [4:0]  R_STAT      = 5'h01;
   localparam logic [4:0]  R_ID1       = 5'h02;
   localparam logic [4:0]  R_ID2       = 5'h03;
   localparam logic [4:0]  R_ADV       = 5'h04;
   localparam logic [4:0]  R_LPA       = 5'h05;
   localparam logic [4:0]  R_EXP       = 5'h06;
   localparam logic [4:0]  R_NP        = 5'h07;
   localparam logic [4:0]  R_CFG       = 5'h10;
   localparam logic [4:0]  R_STAT2     = 5'h11;
   localparam logic [4:0]  R_IEN       = 5'h12;
   localparam logic [4:0]  R_IST       = 5'h13;
   // field positions
   localparam int          B_RST       = 15;
   localparam int          B_SPD       = 13;
   localparam int          B_ANEN      = 12;
   localparam int          B_PDN       = 11;
   localparam int          B_ANRST     = 9;
   localparam int          B_FD        = 8;
   localparam int          B_FIBER     = 0;
   localparam int          B_INTEN     = 1;
   localparam int          EV_HI       = 7;
   localparam int          EV_LO       = 4;
   localparam int          B_AN_DONE   = 5;
   localparam int          B_LINK      = 2;
   localparam int          B2_SPD      = 14;
   localparam int          B2_LINK     = 10;
   localparam int          B2_FD       = 9;
   localparam int          B2_AN_DONE  = 7;
   localparam logic [15:0] CTRL_WMASK  = 16'hff80;
   localparam logic [15:0] STAT_FIXED  = 16'h7809;
   localparam logic [4:0]  SEL_8023    = 5'h01;
   // identifier words, values arbitrary
   localparam logic [15:0] ID1_VAL     = 16'h1234;
   localparam logic [15:0] ID2_VAL     = 16'h5678;

   typedef enum logic [3:0] {
      ST_PRE = 4'h1,
      ST_HDR = 4'h2,
      ST_TA  = 4'h4,
      ST_DAT = 4'h8
   } ppm_mst_e;

   function automatic logic [15:0] ppm_strap_ctrl(input logic [2:0] c);
      ppm_strap_ctrl = 16'h0000;
      ppm_strap_ctrl[B_ANEN] = c[2];
      ppm_strap_ctrl[B_SPD] = c[2] | c[1];
      ppm_strap_ctrl[B_FD] = c[0];
   endfunction : ppm_strap_ctrl

   function automatic logic [15:0] ppm_strap_adv(input logic [2:0] c);
      logic [3:0] ab;
      case (c)
         3'h4:    ab = 4'h4;
         3'h5:    ab = 4'hc;
         3'h6:    ab = 4'h5;
         default: ab = 4'hf;
      endcase
      ppm_strap_adv = {7'h00, ab, SEL_8023};
   endfunction : ppm_strap_adv
endpackage : ppm_pkg

/* src/ppm_port_mgmt.sv */
// six-port management register set, serial management slave and start-up control
// How it works
// - ten sixteen-bit registers per port
// - port address is strap base plus port
// - interrupt only while enable bit 18.1 set
// - one shared active-low interrupt, no port id
// - four causes: autoneg, speed, duplex, link
// - reg 18 enables and masks, 19 status
// - management clock up to 8 MHz
// - data clocks 25 MHz or 2.5 MHz
// - data clock rate chosen automatically
// - reset and link failure consult control bits
// - forced modes start at once, else autoneg
// - bit 11 powers port down, registers kept
// - hardware reset loads speed, autoneg, duplex from straps
// - software reset restores last captured strap values
// - registers unavailable 1 ms after hardware reset
// - bit 15 readable, clears when reset done
// - fiber only through a register write
// - three straps decode to control and advertisement
// - decoded straps are register reset defaults
module ppm_port_mgmt #(
   parameter int P_BUSY_CYC = ppm_pkg::HW_BUSY_CYC
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_mdc,
   input  wire logic        i_mdio,
   output logic             o_mdio,
   output logic             o_mdio_oe,
   input  wire logic [4:0]  i_base_addr,
   input  wire logic [17:0] i_port_strap_led_pin,
   input  wire logic [5:0]  i_link_up,
   input  wire logic [5:0]  i_an_done,
   input  wire logic [5:0]  i_res_speed100,
   input  wire logic [5:0]  i_res_full_duplex,
   output logic      [5:0]  o_mii_clk,
   output logic      [5:0]  o_speed100,
   output logic      [5:0]  o_full_duplex,
   output logic      [5:0]  o_fiber,
   output logic      [5:0]  o_pwrdn,
   output logic      [5:0]  o_an_start,
   output logic             o_shared_irq_n,
   output logic             o_regs_ready
);
   typedef struct packed {
      ppm_pkg::ppm_mst_e st;
      logic [5:0]        cnt;
      logic [15:0]       sh;
      logic              rd;
      logic [2:0]        port;
      logic [4:0]        rg;
      logic [15:0]       wdat;
      logic              rreq_t;
      logic              wreq_t;
      logic              mdo;
      logic              mdoe;
      logic [4:0]        base_s1;
      logic [4:0]        base_s2;
   } ppm_mdc_s;

   typedef struct packed {
      logic [16:0]       busy;
      logic              cap;
      logic [4:0]        base;
      logic [17:0]       strap_s1;
      logic [17:0]       strap_s2;
      logic [17:0]       strap;
      logic [4:0]        base_s1;
      logic [4:0]        base_s2;
      logic [3:0][5:0]   st_s1;
      logic [3:0][5:0]   st_s2;
      logic [2:0]        rreq_s;
      logic [2:0]        wreq_s;
      logic [5:0][15:0]  ctrl;
      logic [5:0][15:0]  adv;
      logic [5:0][15:0]  np;
      logic [5:0][15:0]  cfg;
      logic [5:0][15:0]  ien;
      logic [5:0][15:0]  ist;
      logic [5:0][7:0]   swc;
      logic [5:0][4:0]   clkc;
      logic [5:0]        lnk_p;
      logic [5:0]        an_p;
      logic [15:0]       rdat;
      logic [5:0]        mii_clk;
      logic [5:0]        spd;
      logic [5:0]        fd;
      logic [5:0]        fiber;
      logic [5:0]        pdn;
      logic [5:0]        an_start;
      logic              irq_n;
      logic              ready;
   } ppm_clk_s;

   ppm_mdc_s m_q, m_d;
   ppm_clk_s c_q, c_d;

   // serial frame handling on the management clock
   always_comb begin
      logic [13:0] hw;
      logic [4:0]  off;
      hw = {m_q.sh[12:0], i_mdio};
      off = hw[9:5] - m_q.base_s2;
      m_d = m_q;
      m_d.base_s1 = c_q.base;
      m_d.base_s2 = m_q.base_s1;
      case (m_q.st)
         ppm_pkg::ST_PRE: begin
            if (i_mdio) begin
               if (m_q.cnt != ppm_pkg::PRE_LEN) begin
                  m_d.cnt = m_q.cnt + 6'h01;
               end
            end else if (m_q.cnt == ppm_pkg::PRE_LEN) begin
               m_d.st = ppm_pkg::ST_HDR;
               m_d.sh = 16'h0000;
               m_d.cnt = 6'h01;
            end else begin
               m_d.cnt = 6'h00;
            end
         end
         ppm_pkg::ST_HDR: begin
            m_d.sh = {m_q.sh[14:0], i_mdio};
            m_d.cnt = m_q.cnt + 6'h01;
            if (m_q.cnt == ppm_pkg::HDR_LAST) begin
               m_d.cnt = 6'h00;
               m_d.port = off[2:0];
               m_d.rg = hw[4:0];
               m_d.rd = (hw[11:10] == ppm_pkg::OP_RD);
               if (hw[13:12] == ppm_pkg::SOF && off < 5'(ppm_pkg::NPORT) &&
                   (hw[11:10] == ppm_pkg::OP_RD || hw[11:10] == ppm_pkg::OP_WR)) begin
                  m_d.st = ppm_pkg::ST_TA;
                  m_d.rreq_t = m_q.rreq_t ^ (hw[11:10] == ppm_pkg::OP_RD);
               end else begin
                  m_d.st = ppm_pkg::ST_PRE;
               end
            end
         end
         ppm_pkg::ST_TA: begin
            m_d.cnt = m_q.cnt + 6'h01;
            if (m_q.cnt == 6'h00) begin
               m_d.mdoe = m_q.rd;
               m_d.mdo = 1'b0;
            end else begin
               m_d.st = ppm_pkg::ST_DAT;
               m_d.cnt = 6'h00;
               m_d.mdo = m_q.rd & c_q.rdat[15];
               m_d.sh = {c_q.rdat[14:0], 1'b0};
            end
         end
         ppm_pkg::ST_DAT: begin
            m_d.cnt = m_q.cnt + 6'h01;
            if (m_q.cnt == ppm_pkg::DAT_LAST) begin
               m_d.mdoe = 1'b0;
               m_d.mdo = 1'b0;
               m_d.st = ppm_pkg::ST_PRE;
               m_d.cnt = 6'h00;
            end else begin
               m_d.mdo = m_q.sh[15];
               m_d.sh = {m_q.sh[14:0], 1'b0};
            end
            if (!m_q.rd) begin
               m_d.wdat = {m_q.wdat[14:0], i_mdio};
               if (m_q.cnt == ppm_pkg::DAT_LAST) begin
                  m_d.wreq_t = ~m_q.wreq_t;
               end
            end
         end
         default: begin
            m_d.st = ppm_pkg::ST_PRE;
            m_d.cnt = 6'h00;
         end
      endcase
   end

   always_ff @(posedge i_mdc or posedge i_rst) begin
      if (i_rst) begin
         m_q <= '{st: ppm_pkg::ST_PRE, default: '0};
      end else begin
         m_q <= m_d;
      end
   end

   // register file and port control on the main clock
   always_comb begin
      logic       rd_ev;
      logic       wr_ev;
      logic       an_en;
      logic       nspd;
      logic       nfd;
      logic       start;
      logic       irq;
      logic [2:0] sc;
      logic [3:0] ev;
      c_d = c_q;
      irq = 1'b0;
      c_d.strap_s1 = i_port_strap_led_pin;
      c_d.strap_s2 = c_q.strap_s1;
      c_d.base_s1 = i_base_addr;
      c_d.base_s2 = c_q.base_s1;
      c_d.st_s1 = {i_link_up, i_an_done, i_res_speed100, i_res_full_duplex};
      c_d.st_s2 = c_q.st_s1;
      c_d.rreq_s = {c_q.rreq_s[1:0], m_q.rreq_t};
      c_d.wreq_s = {c_q.wreq_s[1:0], m_q.wreq_t};
      rd_ev = (c_q.rreq_s[2] != c_q.rreq_s[1]) && c_q.ready;
      wr_ev = (c_q.wreq_s[2] != c_q.wreq_s[1]) && c_q.ready;
      c_d.ready = (c_q.busy == 17'(P_BUSY_CYC));
      if (!c_d.ready) begin
         c_d.busy = c_q.busy + 17'h00001;
      end
      if (rd_ev) begin
         c_d.rdat = 16'h0000;
         case (m_q.rg)
            ppm_pkg::R_CTRL:  c_d.rdat = c_q.ctrl[m_q.port];
            ppm_pkg::R_STAT: begin
               c_d.rdat = ppm_pkg::STAT_FIXED;
               c_d.rdat[ppm_pkg::B_LINK] = c_q.lnk_p[m_q.port];
               c_d.rdat[ppm_pkg::B_AN_DONE] = c_q.an_p[m_q.port];
            end
            ppm_pkg::R_ID1:   c_d.rdat = ppm_pkg::ID1_VAL;
            ppm_pkg::R_ID2:   c_d.rdat = ppm_pkg::ID2_VAL;
            ppm_pkg::R_ADV:   c_d.rdat = c_q.adv[m_q.port];
            ppm_pkg::R_NP:    c_d.rdat = c_q.np[m_q.port];
            ppm_pkg::R_CFG:   c_d.rdat = c_q.cfg[m_q.port];
            ppm_pkg::R_STAT2: begin
               c_d.rdat[ppm_pkg::B2_SPD] = c_q.spd[m_q.port];
               c_d.rdat[ppm_pkg::B2_LINK] = c_q.lnk_p[m_q.port];
               c_d.rdat[ppm_pkg::B2_FD] = c_q.fd[m_q.port];
               c_d.rdat[ppm_pkg::B2_AN_DONE] = c_q.an_p[m_q.port];
            end
            ppm_pkg::R_IEN:   c_d.rdat = c_q.ien[m_q.port];
            ppm_pkg::R_IST:   c_d.rdat = c_q.ist[m_q.port];
            default:          c_d.rdat = 16'h0000;
         endcase
      end
      if (!c_q.cap && c_q.busy == ppm_pkg::STRAP_CYC) begin
         c_d.cap = 1'b1;
         c_d.base = c_q.base_s2;
         c_d.strap = c_q.strap_s2;
      end
      for (int p = 0; p < ppm_pkg::NPORT; p++) begin
         sc = c_q.strap_s2[3*p +: 3];
         start = 1'b0;
         if (!c_q.cap && c_q.busy == ppm_pkg::STRAP_CYC) begin
            c_d.ctrl[p] = ppm_pkg::ppm_strap_ctrl(sc);
            c_d.adv[p] = ppm_pkg::ppm_strap_adv(sc);
            start = 1'b1;
         end
         c_d.ctrl[p][ppm_pkg::B_ANRST] = 1'b0;
         if (c_q.ctrl[p][ppm_pkg::B_RST]) begin
            c_d.swc[p] = c_q.swc[p] + 8'h01;
            if (c_q.swc[p] == 8'(ppm_pkg::SW_RST_CYC)) begin
               sc = c_q.strap[3*p +: 3];
               c_d.ctrl[p] = ppm_pkg::ppm_strap_ctrl(sc);
               c_d.adv[p] = ppm_pkg::ppm_strap_adv(sc);
               c_d.np[p] = 16'h0000;
               c_d.cfg[p] = 16'h0000;
               c_d.ien[p] = 16'h0000;
               c_d.swc[p] = 8'h00;
               start = 1'b1;
            end
         end
         if (wr_ev && int'(m_q.port) == p) begin
            case (m_q.rg)
               ppm_pkg::R_CTRL: begin
                  c_d.ctrl[p] = m_q.wdat & ppm_pkg::CTRL_WMASK;
                  start = m_q.wdat[ppm_pkg::B_ANRST];
               end
               ppm_pkg::R_ADV:  c_d.adv[p] = m_q.wdat;
               ppm_pkg::R_NP:   c_d.np[p] = m_q.wdat;
               ppm_pkg::R_CFG:  c_d.cfg[p] = 16'(m_q.wdat[ppm_pkg::B_FIBER]);
               ppm_pkg::R_IEN:  c_d.ien[p] = m_q.wdat;
               default:         c_d.ien[p] = c_q.ien[p];
            endcase
         end
         // next-state mode, so a strap or reset load starts autoneg at once
         an_en = c_d.ctrl[p][ppm_pkg::B_ANEN] && !c_d.cfg[p][ppm_pkg::B_FIBER];
         nspd = c_d.cfg[p][ppm_pkg::B_FIBER] ? 1'b1 :
                an_en ? c_q.st_s2[1][p] : c_d.ctrl[p][ppm_pkg::B_SPD];
         nfd = an_en ? c_q.st_s2[0][p] : c_d.ctrl[p][ppm_pkg::B_FD];
         if (c_q.lnk_p[p] && !c_q.st_s2[3][p]) begin
            start = 1'b1;
         end
         c_d.an_start[p] = start && an_en && !c_d.ctrl[p][ppm_pkg::B_PDN];
         c_d.spd[p] = nspd;
         c_d.fd[p] = nfd;
         c_d.fiber[p] = c_d.cfg[p][ppm_pkg::B_FIBER];
         c_d.pdn[p] = c_q.ctrl[p][ppm_pkg::B_PDN];
         c_d.lnk_p[p] = c_q.st_s2[3][p];
         c_d.an_p[p] = c_q.st_s2[2][p];
         ev = {c_q.st_s2[2][p] & ~c_q.an_p[p], nspd ^ c_q.spd[p],
               nfd ^ c_q.fd[p], c_q.st_s2[3][p] ^ c_q.lnk_p[p]};
         if (!c_q.cap) begin
            ev = 4'h0;
         end
         if (rd_ev && int'(m_q.port) == p && m_q.rg == ppm_pkg::R_IST) begin
            c_d.ist[p] = 16'h0000;
         end
         c_d.ist[p][ppm_pkg::EV_HI:ppm_pkg::EV_LO] =
            c_d.ist[p][ppm_pkg::EV_HI:ppm_pkg::EV_LO] | ev;
         if (c_q.ien[p][ppm_pkg::B_INTEN] &&
             |(c_q.ist[p][ppm_pkg::EV_HI:ppm_pkg::EV_LO] &
               c_q.ien[p][ppm_pkg::EV_HI:ppm_pkg::EV_LO])) begin
            irq = 1'b1;
         end
         if (c_q.ctrl[p][ppm_pkg::B_PDN]) begin
            c_d.clkc[p] = 5'h00;
            c_d.mii_clk[p] = 1'b0;
         end else if (c_q.clkc[p] >= 5'((c_q.spd[p] ? ppm_pkg::HALF100 :
                                         ppm_pkg::HALF10) - 1)) begin
            c_d.clkc[p] = 5'h00;
            c_d.mii_clk[p] = ~c_q.mii_clk[p];
         end else begin
            c_d.clkc[p] = c_q.clkc[p] + 5'h01;
         end
      end
      c_d.irq_n = ~irq;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         c_q <= '{irq_n: 1'b1, default: '0};
      end else begin
         c_q <= c_d;
      end
   end

   assign o_mdio         = m_q.mdo;
   assign o_mdio_oe      = m_q.mdoe;
   assign o_mii_clk      = c_q.mii_clk;
   assign o_speed100     = c_q.spd;
   assign o_full_duplex  = c_q.fd;
   assign o_fiber        = c_q.fiber;
   assign o_pwrdn        = c_q.pdn;
   assign o_an_start     = c_q.an_start;
   assign o_shared_irq_n = c_q.irq_n;
   assign o_regs_ready   = c_q.ready;
endmodule : ppm_port_mgmt

/* sim/ppm_port_mgmt_props.sv */
// assertion checker for the port management block
module ppm_port_mgmt_props #(
   parameter int P_BUSY_CYC = 50
) (
   input wire logic       i_mclk,
   input wire logic       i_rst,
   input wire logic       i_mdc,
   input wire logic       o_mdio,
   input wire logic       o_mdio_oe,
   input wire logic [5:0] o_mii_clk,
   input wire logic [5:0] o_speed100,
   input wire logic [5:0] o_fiber,
   input wire logic [5:0] o_pwrdn,
   input wire logic [5:0] o_an_start,
   input wire logic       o_shared_irq_n,
   input wire logic       o_regs_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   // cycles since reset while not ready
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 0;
      end else if (!o_regs_ready) begin
         cnt_q <= cnt_q + 1;
      end
   end
   a_ready_early: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_regs_ready |-> cnt_q >= P_BUSY_CYC) else $error("ready too early");
   a_ready_late: assert property (@(posedge i_mclk) disable iff (i_rst)
      cnt_q <= P_BUSY_CYC + 8) else $error("ready too late");
   a_quiet_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
      !o_regs_ready |-> !o_mdio_oe && o_shared_irq_n) else $error("activity while busy");
   a_an_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
      (o_an_start & $past(o_an_start)) == 6'h00) else $error("autoneg start not a pulse");
   a_fiber_no_an: assert property (@(posedge i_mclk) disable iff (i_rst)
      (o_an_start & o_fiber) == 6'h00) else $error("autoneg on fiber port");
   a_pdn_clk: assert property (@(posedge i_mclk) disable iff (i_rst)
      (o_pwrdn & $past(o_pwrdn) & o_mii_clk) == 6'h00) else $error("clock in power-down");
   a_fast_clk: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(o_mii_clk[4]) && o_speed100[4] && !o_pwrdn[4] |->
      ##1 o_mii_clk[4] ##1 !o_mii_clk[4]) else $error("fast clock period");
   a_slow_clk: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(o_mii_clk[5]) && !o_speed100[5] && !o_pwrdn[5] |->
      ##19 o_mii_clk[5] ##1 !o_mii_clk[5]) else $error("slow clock period");
   a_read_frame: assert property (@(posedge i_mdc) disable iff (i_rst)
      $rose(o_mdio_oe) |-> !o_mdio ##1 o_mdio_oe [*8]) else $error("read drive too short");
   cover property (@(posedge i_mclk) disable iff (i_rst) $fell(o_shared_irq_n));
   cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_pwrdn[2]));
   cover property (@(posedge i_mdc) disable iff (i_rst) $rose(o_mdio_oe));
endmodule : ppm_port_mgmt_props

bind ppm_port_mgmt ppm_port_mgmt_props #(.P_BUSY_CYC(P_BUSY_CYC)) props_u (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_mdc(i_mdc), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
   .o_mii_clk(o_mii_clk), .o_speed100(o_speed100), .o_fiber(o_fiber), .o_pwrdn(o_pwrdn),
   .o_an_start(o_an_start), .o_shared_irq_n(o_shared_irq_n), .o_regs_ready(o_regs_ready));

/* sim/ppm_mdio_ctl.sv */
// station management controller model
module ppm_mdio_ctl (
   output logic      o_mdc,
   output logic      o_mdio,
   output logic      o_mdio_oe,
   input  wire logic i_mdio
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_mdc = 1'b0;
      o_mdio = 1'b0;
      o_mdio_oe = 1'b0;
   end
   // one clock bit, released line shows inverse
   task automatic bit_out(input logic b, input logic drv);
      o_mdio_oe = drv;
      o_mdio = drv ? b : ~o_mdio;
      #24 o_mdc = 1'b1;
      #24 o_mdc = 1'b0;
   endtask : bit_out
   task automatic hdr(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg);
      logic [13:0] h;
      h = {ppm_pkg::SOF, op, phy, rg};
      for (int i = 0; i < 32; i++) bit_out(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) bit_out(h[i], 1'b1);
   endtask : hdr
   task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
      logic [17:0] w;
      w = {2'b10, d};
      hdr(ppm_pkg::OP_WR, phy, rg);
      for (int i = 17; i >= 0; i--) bit_out(w[i], 1'b1);
      o_mdio_oe = 1'b0;
      #240;
   endtask : wr
   task automatic rd(input logic [4:0] phy, input logic [4:0] rg, output logic [15:0] d);
      hdr(ppm_pkg::OP_RD, phy, rg);
      d = 16'h0000;
      o_mdio_oe = 1'b0;
      for (int k = 46; k < 64; k++) begin
         #24;
         if (k >= 48) d = {d[14:0], i_mdio};
         o_mdc = 1'b1;
         #24 o_mdc = 1'b0;
      end
      #240;
   endtask : rd
endmodule : ppm_mdio_ctl

/* sim/test_phy_port_mgmt_config.sv */
// testbench of the port management block
module test_phy_port_mgmt_config;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0]  BASE   = 5'h1a;
   localparam logic [17:0] STRAPS = {3'h0, 3'h3, 3'h6, 3'h5, 3'h4, 3'h7};
   logic        i_mclk, i_rst, i_mdc, i_mdio, m_mdio, m_oe, o_mdio, o_mdio_oe;
   logic [17:0] i_port_strap_led_pin;
   logic [5:0]  i_link_up, i_an_done, i_res_speed100, i_res_full_duplex;
   logic [5:0]  o_mii_clk, o_speed100, o_full_duplex, o_fiber, o_pwrdn, o_an_start;
   logic        o_shared_irq_n, o_regs_ready;
   logic [15:0] rdat;
   int          err_total, n_compared;
   int          an_cnt [6];
   // pull-up on the shared data line
   assign i_mdio = o_mdio_oe ? o_mdio : (m_oe ? m_mdio : 1'b1);
   ppm_port_mgmt #(.P_BUSY_CYC(50)) dut_u (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_mdc(i_mdc), .i_mdio(i_mdio), .o_mdio(o_mdio),
      .o_mdio_oe(o_mdio_oe), .i_base_addr(BASE), .i_port_strap_led_pin(i_port_strap_led_pin),
      .i_link_up(i_link_up), .i_an_done(i_an_done), .i_res_speed100(i_res_speed100),
      .i_res_full_duplex(i_res_full_duplex), .o_mii_clk(o_mii_clk), .o_speed100(o_speed100),
      .o_full_duplex(o_full_duplex), .o_fiber(o_fiber), .o_pwrdn(o_pwrdn),
      .o_an_start(o_an_start), .o_shared_irq_n(o_shared_irq_n), .o_regs_ready(o_regs_ready));
   ppm_mdio_ctl mdio_u (.o_mdc(i_mdc), .o_mdio(m_mdio), .o_mdio_oe(m_oe), .i_mdio(i_mdio));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      for (int p = 0; p < 6; p++) if (o_an_start[p] === 1'b1) an_cnt[p]++;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : cyc
   task automatic rchk(input int p, input logic [4:0] rg, input logic [15:0] exp);
      mdio_u.rd(BASE + 5'(p), rg, rdat);
      chk($sformatf("reg %0h port %0d", rg, p), exp, rdat);
   endtask : rchk
   task automatic wr(input int p, input logic [4:0] rg, input logic [15:0] d);
      mdio_u.wr(BASE + 5'(p), rg, d);
   endtask : wr
   task automatic tog(input int i);
      @(posedge i_mclk);
      case (i)
         0: i_an_done[0] <= ~i_an_done[0];
         1: i_res_speed100[0] <= ~i_res_speed100[0];
         2: i_res_full_duplex[0] <= ~i_res_full_duplex[0];
         default: i_link_up[0] <= ~i_link_up[0];
      endcase
   endtask : tog
   function automatic logic [15:0] ctl_exp(input logic [2:0] c);
      return {2'b00, c[2] | c[1], c[2], 3'b000, c[0], 8'h00};
   endfunction : ctl_exp
   function automatic logic [15:0] adv_exp(input logic [2:0] c);
      case (c)
         3'h4: return 16'h0081;
         3'h5: return 16'h0181;
         3'h6: return 16'h00a1;
         default: return 16'h01e1;
      endcase
   endfunction : adv_exp
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #800us;
      err_total++;
      $display("CHECK FAILED watchdog expected done seen hang");
      end_of_test();
   end
   initial begin
      i_rst = 1'b1;
      i_port_strap_led_pin = STRAPS;
      {i_link_up, i_an_done, i_res_speed100, i_res_full_duplex} = '0;
      repeat (10) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (int k = 0; k < 200 && o_regs_ready !== 1'b1; k++) cyc(1);
      chk("ready", 16'h0001, {15'h0, o_regs_ready});
      for (int p = 0; p < 6; p++) begin
         rchk(p, ppm_pkg::R_CTRL, ctl_exp(STRAPS[3*p +: 3]));
         rchk(p, ppm_pkg::R_ADV, adv_exp(STRAPS[3*p +: 3]));
         chk("autoneg start", {15'h0, p < 4}, {15'h0, an_cnt[p] > 0});
      end
      chk("forced mode", 16'h0005, {12'h0, o_speed100[5:4], o_full_duplex[5:4]});
      chk("fiber", 16'h0000, {10'h0, o_fiber});
      $display("test straps done");
      mdio_u.rd(BASE - 5'h01, ppm_pkg::R_CTRL, rdat);
      chk("foreign address", 16'hffff, rdat);
      wr(0, 5'h1f, 16'hffff);
      rchk(0, 5'h1f, 16'h0000);
      $display("test address done");
      wr(1, ppm_pkg::R_CTRL, 16'h0100);
      rchk(1, ppm_pkg::R_CTRL, 16'h0100);
      @(posedge i_mclk);
      i_port_strap_led_pin[5:3] <= 3'h0;
      wr(1, ppm_pkg::R_CTRL, 16'h8000);
      rdat = 16'h8000;
      for (int k = 0; k < 10 && rdat[15] !== 1'b0; k++) begin
         mdio_u.rd(BASE + 5'h01, ppm_pkg::R_CTRL, rdat);
      end
      chk("soft reset ctrl", ctl_exp(3'h4), rdat);
      $display("test soft reset done");
      wr(2, ppm_pkg::R_CTRL, 16'h3900);
      chk("power-down", 16'h0004, {10'h0, o_pwrdn});
      wr(2, ppm_pkg::R_ADV, 16'h0061);
      rchk(2, ppm_pkg::R_ADV, 16'h0061);
      rchk(2, ppm_pkg::R_CTRL, 16'h3900);
      wr(2, ppm_pkg::R_CTRL, 16'h3100);
      chk("power-up", 16'h0000, {10'h0, o_pwrdn});
      wr(4, ppm_pkg::R_CFG, 16'h0001);
      chk("fiber", 16'h0010, {10'h0, o_fiber});
      $display("test power and fiber done");
      wr(0, ppm_pkg::R_IEN, 16'h00f0);
      tog(3);
      cyc(40);
      chk("masked irq", 16'h0001, {15'h0, o_shared_irq_n});
      mdio_u.rd(BASE, ppm_pkg::R_IST, rdat);
      wr(0, ppm_pkg::R_IEN, 16'h00f2);
      for (int i = 0; i < 4; i++) begin
         tog(i);
         for (int k = 0; k < 40 && o_shared_irq_n !== 1'b0; k++) cyc(1);
         chk("irq low", 16'h0000, {15'h0, o_shared_irq_n});
         rchk(0, ppm_pkg::R_IST, 16'h0080 >> i);
         cyc(10);
         chk("irq released", 16'h0001, {15'h0, o_shared_irq_n});
      end
      $display("test interrupt done");
      end_of_test();
   end
endmodule : test_phy_port_mgmt_config
